/* File: hwlu_pkg.sv */
package hwlu_pkg;

	// ------------------------------------------------------------
	// opcode ranges (upper opcode bits)
	// ------------------------------------------------------------
	localparam logic [7:0] HWLU_OPC_HALF_POST = 8'h2d;
	localparam logic [7:0] HWLU_OPC_WORD_IND  = 8'h30;
	localparam logic [7:0] HWLU_OPC_WORD_POST = 8'h31;
	localparam logic [7:0] HWLU_OPC_MOVE_GEN  = 8'h2e;
	localparam logic [9:0] HWLU_OPC_MOVE_SPEC = 10'h290;
	localparam logic [5:0] HWLU_OPC_HALF_SP   = 6'h13;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int HWLU_SRC_LSB  = 4;
	localparam int HWLU_DST_LSB  = 0;
	localparam int HWLU_DISP_LSB = 4;

	// ------------------------------------------------------------
	// post-increment steps and special register codes
	// ------------------------------------------------------------
	localparam logic [31:0] HWLU_INC_HALF = 32'h0000_0002;
	localparam logic [31:0] HWLU_INC_WORD = 32'h0000_0004;
	localparam logic [1:0]  HWLU_SS_SP    = 2'h0;
	localparam logic [1:0]  HWLU_SS_FLAGS = 2'h1;
	localparam logic [1:0]  HWLU_SS_MLO   = 2'h2;
	localparam logic [1:0]  HWLU_SS_MHI   = 2'h3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		HWLU_OP_NONE,
		HWLU_OP_HALF_POST,
		HWLU_OP_HALF_SP,
		HWLU_OP_WORD_IND,
		HWLU_OP_WORD_POST,
		HWLU_OP_MOVE_GEN,
		HWLU_OP_MOVE_SPEC
	} hwlu_op_type;

	typedef enum logic [1:0] {
		HWLU_ST_IDLE  = 2'b00,
		HWLU_ST_MEM   = 2'b01,
		HWLU_ST_INCR  = 2'b11,
		HWLU_ST_STALL = 2'b10
	} hwlu_state_type;

	typedef struct packed {
		logic        valid;
		logic [15:0] opcode;
		logic [1:0]  ext_count;
		logic [12:0] ext_first;
		logic [12:0] ext_second;
	} hwlu_insn_type;

	typedef struct packed {
		logic        we;
		logic [3:0]  idx;
		logic [31:0] data;
	} hwlu_wb_type;

	typedef struct packed {
		logic        req;
		logic [31:0] addr;
		logic        word;
	} hwlu_mem_type;

endpackage

/* File: hwlu_unit.sv */
// Operation
// - post-increment half load: zero-extend into dest, base plus 2, two cycles
// - half load with odd effective address raises address error, no access
// - half load: byte at address to bits 7:0, next byte to 15:8
// - post-increment with dest equal base leaves the incremented address
// - unprefixed stack half load: stack_ptr plus twice short_disp_field
// - one prefix: 19-bit displacement, prefix_value over the 6-bit field
// - two prefixes: 32-bit displacement, first prefix highest
// - prefixed stack half load forces field bit 0 to zero
// - single-cycle loads stall one cycle if next insn uses dest
// - general register word move copies 32 bits in one cycle
// - opcodes 0xA400-0xA43F copy a special register into a general one
// - without multiplier, moves from multiply accumulators are no-ops
// - one prefix indirect word load: base plus 13-bit prefix, base kept
// - two prefixes indirect word load: base plus 26-bit displacement
// - word load with nonzero low two address bits raises address error
// - word load reads four bytes, byte at address in bits 7:0
// - post-increment word load: load dest, base plus 4, two cycles
// - opcodes 0x2D00-0x2DFF are post-increment half loads
// - opcodes 0x3000-0x30FF are register-indirect word loads
// - opcodes 0x3100-0x31FF are post-increment word loads
// - post-increment loads and moves refuse any prefix
module hwlu_unit
	import hwlu_pkg::*;
#(
	parameter int MULT_EN = 1
) (
	input  wire logic          sys_clk_i,
	input  wire logic          nrst_i,
	input  wire hwlu_insn_type insn_i,
	input  wire logic [31:0]   src_data_i,
	input  wire logic [31:0]   sp_i,
	input  wire logic [31:0]   psr_i,
	input  wire logic [31:0]   alr_i,
	input  wire logic [31:0]   ahr_i,
	input  wire logic          next_valid_i,
	input  wire logic [15:0]   next_opcode_i,
	input  wire logic          mem_rvalid_i,
	input  wire logic [31:0]   mem_rdata_i,
	output logic               accept_o,
	output logic               busy_o,
	output logic               stall_o,
	output hwlu_mem_type       mem_o,
	output hwlu_wb_type        wb_o,
	output logic               addr_err_o,
	output logic               illegal_o
);

	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	generate
		if (MULT_EN != 0 && MULT_EN != 1) begin : g_bad_mult
			$error("MULT_EN must be 0 or 1");
		end
	endgenerate

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic hwlu_op_type op_decode(input logic [15:0] opc);
		hwlu_op_type k;
		k = HWLU_OP_NONE;
		if (opc[15:8] == HWLU_OPC_HALF_POST) begin
			k = HWLU_OP_HALF_POST;
		end else if (opc[15:8] == HWLU_OPC_WORD_IND) begin
			k = HWLU_OP_WORD_IND;
		end else if (opc[15:8] == HWLU_OPC_WORD_POST) begin
			k = HWLU_OP_WORD_POST;
		end else if (opc[15:8] == HWLU_OPC_MOVE_GEN) begin
			k = HWLU_OP_MOVE_GEN;
		end else if (opc[15:6] == HWLU_OPC_MOVE_SPEC) begin
			k = HWLU_OP_MOVE_SPEC;
		end else if (opc[15:10] == HWLU_OPC_HALF_SP) begin
			k = HWLU_OP_HALF_SP;
		end
		return k;
	endfunction

	function automatic logic is_post(input hwlu_op_type k);
		return (k == HWLU_OP_HALF_POST) || (k == HWLU_OP_WORD_POST);
	endfunction

	hwlu_op_type    kind;
	logic [3:0]     src_idx;
	logic [3:0]     dst_idx;
	logic [5:0]     disp6;
	logic [1:0]     ss_sel;
	logic [31:0]    eff_addr;
	logic           is_word;
	logic           misaligned;
	logic           bad_prefix;
	logic           mul_nop;
	logic [31:0]    spec_data;
	logic           hazard;
	logic [31:0]    load_data;

	assign kind    = op_decode(insn_i.opcode);
	assign src_idx = insn_i.opcode[HWLU_SRC_LSB +: 4];
	assign dst_idx = insn_i.opcode[HWLU_DST_LSB +: 4];
	assign disp6   = insn_i.opcode[HWLU_DISP_LSB +: 6];
	assign ss_sel  = insn_i.opcode[HWLU_SRC_LSB +: 2];
	assign is_word = (kind == HWLU_OP_WORD_IND) || (kind == HWLU_OP_WORD_POST);

	// ------------------------------------------------------------
	// effective address
	// ------------------------------------------------------------
	always_comb begin
		eff_addr = src_data_i;
		case (kind)
			HWLU_OP_HALF_SP: begin
				case (insn_i.ext_count)
					2'd0: eff_addr = sp_i + {25'h0, disp6, 1'b0};
					2'd1: eff_addr = sp_i + {13'h0, insn_i.ext_first,
						disp6[5:1], 1'b0};
					default: eff_addr = sp_i + {insn_i.ext_first,
						insn_i.ext_second, disp6[5:1], 1'b0};
				endcase
			end
			HWLU_OP_WORD_IND: begin
				case (insn_i.ext_count)
					2'd0: eff_addr = src_data_i;
					2'd1: eff_addr = src_data_i
						+ {19'h0, insn_i.ext_first};
					default: eff_addr = src_data_i + {6'h0,
						insn_i.ext_first, insn_i.ext_second};
				endcase
			end
			default: eff_addr = src_data_i;
		endcase
	end

	// an odd stack pointer can still misalign a prefixed stack load
	assign misaligned = is_word ? (eff_addr[1:0] != 2'b00)
		: eff_addr[0];
	assign bad_prefix = (insn_i.ext_count != 2'd0)
		&& (is_post(kind) || kind == HWLU_OP_MOVE_GEN
		|| kind == HWLU_OP_MOVE_SPEC);
	assign mul_nop = (MULT_EN == 0) && ss_sel[1];

	always_comb begin
		case (ss_sel)
			HWLU_SS_SP:    spec_data = sp_i;
			HWLU_SS_FLAGS: spec_data = psr_i;
			HWLU_SS_MLO:   spec_data = alr_i;
			HWLU_SS_MHI:   spec_data = ahr_i;
			default:       spec_data = sp_i;
		endcase
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	hwlu_state_type state_reg;
	hwlu_state_type state_next;
	hwlu_mem_type   mem_reg;
	hwlu_mem_type   mem_next;
	hwlu_wb_type    wb_reg;
	hwlu_wb_type    wb_next;
	logic [3:0]     dst_reg;
	logic [3:0]     dst_next;
	logic [3:0]     base_reg;
	logic [3:0]     base_next;
	logic           post_reg;
	logic           post_next;
	logic           err_reg;
	logic           err_next;
	logic           ill_reg;
	logic           ill_next;

	assign accept_o = (state_reg == HWLU_ST_IDLE) && insn_i.valid
		&& (kind != HWLU_OP_NONE);
	assign busy_o   = (state_reg != HWLU_ST_IDLE);
	assign stall_o  = (state_reg == HWLU_ST_STALL);

	// next insn naming the loaded register as any operand
	assign hazard = next_valid_i
		&& (next_opcode_i[HWLU_SRC_LSB +: 4] == dst_reg
		|| next_opcode_i[HWLU_DST_LSB +: 4] == dst_reg);

	// byte lane 0 is the byte at the effective address
	assign load_data = mem_reg.word ? mem_rdata_i
		: {16'h0000, mem_rdata_i[15:8], mem_rdata_i[7:0]};

	always_comb begin
		state_next = state_reg;
		mem_next   = mem_reg;
		wb_next    = '0;
		dst_next   = dst_reg;
		base_next  = base_reg;
		post_next  = post_reg;
		err_next   = 1'b0;
		ill_next   = 1'b0;
		case (state_reg)
			HWLU_ST_IDLE: begin
				if (accept_o) begin
					if (bad_prefix) begin
						ill_next = 1'b1;
					end else if (kind == HWLU_OP_MOVE_GEN) begin
						wb_next = '{1'b1, dst_idx, src_data_i};
					end else if (kind == HWLU_OP_MOVE_SPEC) begin
						wb_next = '{!mul_nop, dst_idx, spec_data};
					end else if (misaligned) begin
						err_next = 1'b1;
					end else begin
						mem_next  = '{1'b1, eff_addr, is_word};
						dst_next  = dst_idx;
						base_next = src_idx;
						post_next = is_post(kind);
						state_next = HWLU_ST_MEM;
					end
				end
			end
			HWLU_ST_MEM: begin
				if (mem_rvalid_i) begin
					mem_next.req = 1'b0;
					wb_next = '{1'b1, dst_reg, load_data};
					if (post_reg) begin
						state_next = HWLU_ST_INCR;
					end else if (hazard) begin
						state_next = HWLU_ST_STALL;
					end else begin
						state_next = HWLU_ST_IDLE;
					end
				end
			end
			HWLU_ST_INCR: begin
				// base write comes last so a shared register keeps it
				wb_next = '{1'b1, base_reg, mem_reg.addr
					+ (mem_reg.word ? HWLU_INC_WORD : HWLU_INC_HALF)};
				state_next = HWLU_ST_IDLE;
			end
			HWLU_ST_STALL: begin
				state_next = HWLU_ST_IDLE;
			end
			default: begin
				state_next = HWLU_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= HWLU_ST_IDLE;
			mem_reg   <= '0;
			wb_reg    <= '0;
			dst_reg   <= 4'h0;
			base_reg  <= 4'h0;
			post_reg  <= 1'b0;
			err_reg   <= 1'b0;
			ill_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			mem_reg   <= mem_next;
			wb_reg    <= wb_next;
			dst_reg   <= dst_next;
			base_reg  <= base_next;
			post_reg  <= post_next;
			err_reg   <= err_next;
			ill_reg   <= ill_next;
		end
	end

	// only general registers are written; the flags word is never a target
	assign wb_o       = wb_reg;
	assign mem_o      = mem_reg;
	assign addr_err_o = err_reg;
	assign illegal_o  = ill_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence post_load_s;
		(state_reg == HWLU_ST_MEM) && mem_rvalid_i && post_reg;
	endsequence

	sequence two_writes_s;
		wb_o.we && wb_o.idx == $past(dst_reg) ##1
		wb_o.we && wb_o.idx == $past(base_reg, 2);
	endsequence

	post_two_cycle_a: assert property (
		post_load_s |=> two_writes_s
	) else $error("post-increment load did not write dest then base");

	half_align_a: assert property (
		accept_o && !bad_prefix && !is_word
		&& (kind == HWLU_OP_HALF_POST || kind == HWLU_OP_HALF_SP)
		&& eff_addr[0]
		|=> addr_err_o && !mem_o.req ##1 !addr_err_o
	) else $error("odd half address not faulted");

	half_zext_a: assert property (
		(state_reg == HWLU_ST_MEM) && mem_rvalid_i && !mem_reg.word
		|=> wb_o.data == {16'h0000, $past(mem_rdata_i[15:0])}
	) else $error("half load data not zero extended");

	base_last_a: assert property (
		(state_reg == HWLU_ST_INCR) && (dst_reg == base_reg)
		|=> wb_o.we && wb_o.idx == $past(dst_reg)
		&& wb_o.data == $past(mem_reg.addr) + ($past(mem_reg.word)
		? HWLU_INC_WORD : HWLU_INC_HALF) && state_reg == HWLU_ST_IDLE
	) else $error("shared register not left at incremented address");

	sp_short_a: assert property (
		accept_o && kind == HWLU_OP_HALF_SP && insn_i.ext_count == 2'd0
		&& !eff_addr[0]
		|=> mem_o.req && mem_o.addr
		== $past(sp_i) + {25'h0, $past(disp6), 1'b0}
	) else $error("stack half address wrong");

	word_align_a: assert property (
		accept_o && !bad_prefix && is_word && eff_addr[1:0] != 2'b00
		|=> addr_err_o && state_reg == HWLU_ST_IDLE
	) else $error("misaligned word not faulted");

	stall_once_a: assert property (
		(state_reg == HWLU_ST_MEM) && mem_rvalid_i && !post_reg && hazard
		|=> stall_o ##1 !stall_o
	) else $error("load-use stall not exactly one cycle");

	move_one_a: assert property (
		accept_o && kind == HWLU_OP_MOVE_GEN && !bad_prefix
		|=> wb_o.we && wb_o.data == $past(src_data_i) && !busy_o
	) else $error("register move not single cycle");

	prefix_bad_a: assert property (
		accept_o && bad_prefix
		|=> illegal_o && !wb_o.we && !mem_o.req
	) else $error("prefixed form not refused");

	mul_nop_a: assert property (
		accept_o && kind == HWLU_OP_MOVE_SPEC && mul_nop && !bad_prefix
		|=> !wb_o.we && !busy_o
	) else $error("accumulator move not a no-op");

endmodule

/* File: hwlu_mem_model.sv */
module hwlu_mem_model
	import hwlu_pkg::*;
(
	input  wire logic         sys_clk_i,
	input  wire logic         nrst_i,
	input  wire hwlu_mem_type mem_i,
	input  wire logic [3:0]   lat_i,
	output logic              rvalid_o,
	output logic [31:0]       rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] cnt_reg;

	// ------------------------------------------------------------
	// byte contents, a fold of the address
	// ------------------------------------------------------------
	function automatic logic [7:0] bval(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'h3c;
	endfunction

	// ------------------------------------------------------------
	// answer lat_i cycles after the request is seen
	// ------------------------------------------------------------
	// off the answer the data lines toggle, so stale data never matches
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_reg  <= 4'h0;
			rvalid_o <= 1'b0;
			rdata_o  <= 32'h0000_0000;
		end else if (mem_i.req && !rvalid_o && cnt_reg == lat_i) begin
			cnt_reg  <= 4'h0;
			rvalid_o <= 1'b1;
			// lane 0 is the byte at the address
			rdata_o  <= {bval(mem_i.addr + 32'h0000_0003),
				bval(mem_i.addr + 32'h0000_0002),
				bval(mem_i.addr + 32'h0000_0001), bval(mem_i.addr)};
		end else begin
			cnt_reg  <= (mem_i.req && !rvalid_o) ? cnt_reg + 4'h1 : 4'h0;
			rvalid_o <= 1'b0;
			rdata_o  <= ~rdata_o;
		end
	end
endmodule

/* File: half_and_word_load_unit_test.sv */
module half_and_word_load_unit_test
	import hwlu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] PSR = 32'h1111_2222;
	localparam logic [31:0] ALR = 32'h3333_4444;
	localparam logic [31:0] AHR = 32'h5555_6666;

	logic          sys_clk_i = 1'b0;
	logic          nrst_i = 1'b0;
	logic          nv = 1'b0;
	logic          acc, busy, stall, rv, aerr, ill;
	hwlu_insn_type insn = '0;
	logic [31:0]   src = '0;
	logic [31:0]   sp = '0;
	logic [31:0]   rdata;
	logic [15:0]   nop = '0;
	logic [3:0]    lat = '0;
	hwlu_mem_type  mem;
	hwlu_wb_type   wb, wb2;
	int            n_mismatch = 0;
	int            cmp_count = 0;
	int            n_err, n_ill, n_stall, n_wb2, n_acc;
	logic [35:0]   q[$];

	// ------------------------------------------------------------
	// units under test and memory
	// ------------------------------------------------------------
	hwlu_unit u_hwlu_unit (.sys_clk_i, .nrst_i, .insn_i(insn),
		.src_data_i(src), .sp_i(sp), .psr_i(PSR), .alr_i(ALR), .ahr_i(AHR),
		.next_valid_i(nv), .next_opcode_i(nop), .mem_rvalid_i(rv),
		.mem_rdata_i(rdata), .accept_o(acc), .busy_o(busy), .stall_o(stall),
		.mem_o(mem), .wb_o(wb), .addr_err_o(aerr), .illegal_o(ill));
	// core built without the multiplier, watched on moves only
	hwlu_unit #(.MULT_EN(0)) u_hwlu_unit_nomul (.sys_clk_i, .nrst_i,
		.insn_i(insn), .src_data_i(src), .sp_i(sp), .psr_i(PSR),
		.alr_i(ALR), .ahr_i(AHR), .next_valid_i(nv), .next_opcode_i(nop),
		.mem_rvalid_i(rv), .mem_rdata_i(rdata), .accept_o(), .busy_o(),
		.stall_o(), .mem_o(), .wb_o(wb2), .addr_err_o(), .illegal_o());
	hwlu_mem_model u_hwlu_mem_model (.sys_clk_i, .nrst_i, .mem_i(mem),
		.lat_i(lat), .rvalid_o(rv), .rdata_o(rdata));

	always #2 sys_clk_i = ~sys_clk_i;

	always @(negedge sys_clk_i) begin
		if (wb.we === 1'b1)
			q.push_back({wb.idx, wb.data});
		n_err += int'(aerr === 1'b1);
		n_ill += int'(ill === 1'b1);
		n_stall += int'(stall === 1'b1);
		n_wb2 += int'(wb2.we === 1'b1);
		n_acc += int'(acc === 1'b1);
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	function automatic logic [7:0] bv(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'h3c;
	endfunction

	function automatic logic [31:0] wx(input logic [31:0] a, input bit h);
		logic [31:0] w;
		w = {bv(a + 32'h3), bv(a + 32'h2), bv(a + 32'h1), bv(a)};
		return h ? {16'h0000, w[15:0]} : w;
	endfunction

	task automatic chk(input string nm, input logic [35:0] s, e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	// one instruction, held until taken, then wait for idle
	task automatic run(input logic [15:0] op, input logic [1:0] c,
		input logic [12:0] f, s);
		@(posedge sys_clk_i);
		insn <= '{1'b1, op, c, f, s};
		// cleared on the rising edge so the negedge monitor never races it
		q.delete();
		n_err = 0;
		n_ill = 0;
		n_stall = 0;
		n_wb2 = 0;
		n_acc = 0;
		@(negedge sys_clk_i);
		for (int i = 0; i < 20 && acc !== 1'b1; i++) @(negedge sys_clk_i);
		@(posedge sys_clk_i);
		insn.valid <= 1'b0;
		@(negedge sys_clk_i);
		for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge sys_clk_i);
		repeat (3) @(negedge sys_clk_i);
	endtask

	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_special();
		logic [31:0] v[4];
		v = '{32'h0010_0000, PSR, ALR, AHR};
		@(posedge sys_clk_i);
		sp <= v[0];
		for (int k = 0; k < 4; k++) begin
			run({10'h290, 2'(k), 4'h3}, 2'h0, 13'h0, 13'h0);
			chk("smove", q[0], {4'h3, v[k]});
			chk("nomul", 36'(n_wb2), 36'(k < 2));
		end
	endtask

	task automatic t_moves();
		@(posedge sys_clk_i);
		src <= 32'hcafe_f00d;
		run(16'h2e7b, 2'h0, 13'h0, 13'h0);
		chk("gmove", q[0], {4'hb, 32'hcafe_f00d});
		run(16'h2e7b, 2'h1, 13'h5, 13'h0);
		chk("mvpre", 36'(n_ill * 2 + q.size()), 36'h2);
		run(16'h0000, 2'h0, 13'h0, 13'h0);
		chk("undef", 36'(n_acc + q.size()), 36'h0);
	endtask

	task automatic t_ind();
		logic [31:0] b;
		b = 32'h0001_0100;
		@(posedge sys_clk_i);
		src <= b;
		lat <= 4'h3;
		run(16'h3025, 2'h0, 13'h0, 13'h0);
		chk("ind0", q[0], {4'h5, wx(b, 0)});
		run(16'h3025, 2'h1, 13'h0124, 13'h0);
		chk("ind1", q[0], {4'h5, wx(b + 32'h124, 0)});
		run(16'h3025, 2'h2, 13'h0002, 13'h0040);
		chk("ind2", q[0], {4'h5, wx(b + 32'h4040, 0)});
		chk("keep", 36'(q.size()), 36'h1);
		run(16'h3025, 2'h1, 13'h0002, 13'h0);
		chk("walign", 36'(n_err * 2 + q.size()), 36'h2);
	endtask

	task automatic t_post();
		logic [31:0] b;
		b = 32'h0002_0034;
		@(posedge sys_clk_i);
		src <= b;
		lat <= 4'h0;
		run(16'h2d45, 2'h0, 13'h0, 13'h0);
		chk("hpost", q[0], {4'h5, wx(b, 1)});
		chk("hinc", q[1], {4'h4, b + 32'h2});
		run(16'h2d44, 2'h0, 13'h0, 13'h0);
		chk("same", q[$], {4'h4, b + 32'h2});
		run(16'h3145, 2'h0, 13'h0, 13'h0);
		chk("wpost", q[0], {4'h5, wx(b, 0)});
		chk("winc", q[1], {4'h4, b + 32'h4});
		run(16'h2d45, 2'h2, 13'h1, 13'h1);
		chk("pipre", 36'(n_ill * 2 + q.size()), 36'h2);
		@(posedge sys_clk_i);
		src <= b + 32'h1;
		run(16'h2d45, 2'h0, 13'h0, 13'h0);
		chk("halign", 36'(n_err * 2 + q.size()), 36'h2);
	endtask

	task automatic t_stack();
		@(posedge sys_clk_i);
		sp <= 32'h0010_0000;
		run(16'h4eb6, 2'h0, 13'h0, 13'h0);
		chk("sp0", q[0], {4'h6, wx(32'h0010_0056, 1)});
		run(16'h4eb6, 2'h1, 13'h0011, 13'h0);
		chk("sp1", q[0], {4'h6, wx(32'h0010_046a, 1)});
		run(16'h4eb6, 2'h2, 13'h0001, 13'h0);
		chk("sp2", q[0], {4'h6, wx(32'h0018_002a, 1)});
	endtask

	task automatic t_stall();
		@(posedge sys_clk_i);
		src <= 32'h0000_0200;
		nv <= 1'b1;
		nop <= 16'h2e53;
		run(16'h3013, 2'h0, 13'h0, 13'h0);
		chk("stall", 36'(n_stall), 36'h1);
		@(posedge sys_clk_i);
		nop <= 16'h2e54;
		run(16'h3013, 2'h0, 13'h0, 13'h0);
		chk("nostall", 36'(n_stall), 36'h0);
		@(posedge sys_clk_i);
		nv <= 1'b0;
	endtask

	initial begin
		#(20000 * 4);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		repeat (4) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		t_special();
		t_moves();
		t_ind();
		t_post();
		t_stack();
		t_stall();
		tally_and_finish();
	end
endmodule
